// [src/stc_map.svh]
// register offsets, field positions and reset values of the 16-bit timer/counter
// assumes an 8-bit i/o register port addressed by these byte offsets
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
`define STC_ADDR_CNT_LO 6'h2c
`define STC_ADDR_CNT_HI 6'h2d
`define STC_ADDR_CTRL_B 6'h2e
`define STC_ADDR_CTRL_A 6'h2f
`define STC_ADDR_CMPA_LO 6'h2a
`define STC_ADDR_CMPA_HI 6'h2b
`define STC_ADDR_CMPB_LO 6'h28
`define STC_ADDR_CMPB_HI 6'h29
`define STC_ADDR_CAP_LO 6'h24
`define STC_ADDR_CAP_HI 6'h25
`define STC_ADDR_FLAGS 6'h38
`define STC_ADDR_MASK 6'h39
`define STC_CTRL_A_WMASK 8'hf3
`define STC_CTRL_B_WMASK 8'hcf
`define STC_FLAG_OVF 0
`define STC_FLAG_CMPA 1
`define STC_FLAG_CMPB 2
`define STC_FLAG_CAP 3
`define STC_RESET_BYTE 8'h00
`define STC_RESET_WORD 16'h0000
`define STC_FILTER_SAMPLES 4
`define STC_PRESCALE_TOP 10'h3ff
`endif

// [src/stc_pkg.sv]
// types shared by the 16-bit timer/counter
// assumes stc_map.svh holds the register offsets, write masks, flag positions and reset values
package stc_pkg;
    typedef enum logic [2:0] {
        STC_CLK_STOP, STC_CLK_DIV1, STC_CLK_DIV8, STC_CLK_DIV64,
        STC_CLK_DIV256, STC_CLK_DIV1024, STC_CLK_EXT_FALL, STC_CLK_EXT_RISE
    } stc_clk_sel_e;

    typedef struct packed {
        logic [1:0] compare_a_mode;
        logic [1:0] compare_b_mode;
        logic [1:0] reserved;
        logic [1:0] pwm_resolution;
    } stc_ctrl_a_s;

    typedef struct packed {
        logic capture_noise_filter;
        logic capture_edge_select;
        logic [1:0] reserved;
        logic clear_on_match_a;
        stc_clk_sel_e clock_sel;
    } stc_ctrl_b_s;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } stc_bus_req_s;
endpackage : stc_pkg

// [src/stc_timer.sv]
// 16-bit timer/counter with two compare outputs, pwm and input capture
// assumes one 100 mhz clock, a synchronous i/o byte port, async pins
//
// Operation
// - clock select picks stop, prescale or pin
// - pin edges count even when pin outputs
// - count pin synchronised before edge detect
// - compare mode: off, toggle, clear, set
// - pin action gated by direction bit
// - reserved control bits read zero
// - pwm select: off, 8, 9, 10 bit
// - filter needs four equal samples
// - edge select falling zero, rising one
// - comparator may replace capture pin
// - clear on match a next cycle
// - match seen cycle after, then zero
// - clear on match ignored in pwm
// - flags and masks in shared registers
// - both compares checked on each tick
// - high write latched, low write loads
// - low read latches high byte
// - pwm counts up to top and down
// - pwm mode 10 sets up, clears down
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_timer
    import stc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // pins
    input wire logic external_count_pin_i,
    input wire logic capture_trigger_pin_i,
    input wire logic comparator_result_i,
    input wire logic comparator_capture_select_i,
    input wire logic compare_a_dir_i,
    input wire logic compare_b_dir_i,
    output logic compare_a_output_pin_o,
    output logic compare_a_output_pin_oe_o,
    output logic compare_b_output_pin_o,
    output logic compare_b_output_pin_oe_o,
    // status and mask
    output logic [3:0] timer_flags_o,
    output logic irq_o
);
    stc_bus_req_s req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    stc_ctrl_a_s ctrl_a_reg, ctrl_a_next;
    stc_ctrl_b_s ctrl_b_reg, ctrl_b_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] cmpa_reg, cmpa_next, cmpb_reg, cmpb_next;
    logic [15:0] cmpa_buf_reg, cmpa_buf_next, cmpb_buf_reg, cmpb_buf_next;
    logic [15:0] cap_reg, cap_next;
    logic [7:0] temp_reg, temp_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [3:0] flags_reg, flags_next;
    logic [3:0] mask_reg, mask_next;
    logic [9:0] pre_reg, pre_next;
    logic down_reg, down_next;
    logic oca_reg, oca_next, ocb_reg, ocb_next;
    logic mata_reg, mata_next, matb_reg, matb_next;
    logic [1:0] ext_sync_reg, ext_sync_next;
    logic ext_prev_reg, ext_prev_next;
    logic [1:0] cap_sync_reg, cap_sync_next;
    logic [3:0] cap_hist_reg, cap_hist_next;
    logic cap_level_reg, cap_level_next;

    logic tick, pwm_on, cap_src, cap_hit, wrote_cnt;
    logic [15:0] top;

    // two-stage synchronisers; only the second stage feeds logic
    always_comb begin
        ext_sync_next = {ext_sync_reg[0], external_count_pin_i};
        cap_src = comparator_capture_select_i ? comparator_result_i
                                              : capture_trigger_pin_i;
        cap_sync_next = {cap_sync_reg[0], cap_src};
        ext_prev_next = ext_sync_reg[1];
        cap_hist_next = {cap_hist_reg[2:0], cap_sync_reg[1]};
    end

    // tick selection from the free-running prescaler or the synchronised count pin
    always_comb begin
        pre_next = pre_reg + 10'h001;
        unique case (ctrl_b_reg.clock_sel)
            STC_CLK_STOP: tick = 1'b0;
            STC_CLK_DIV1: tick = 1'b1;
            STC_CLK_DIV8: tick = (pre_reg[2:0] == 3'h7);
            STC_CLK_DIV64: tick = (pre_reg[5:0] == 6'h3f);
            STC_CLK_DIV256: tick = (pre_reg[7:0] == 8'hff);
            STC_CLK_DIV1024: tick = (pre_reg == `STC_PRESCALE_TOP);
            STC_CLK_EXT_FALL: tick = ext_prev_reg & ~ext_sync_reg[1];
            STC_CLK_EXT_RISE: tick = ~ext_prev_reg & ext_sync_reg[1];
        endcase
    end

    // capture edge and noise filter
    always_comb begin
        cap_level_next = cap_level_reg;
        cap_hit = 1'b0;
        if (ctrl_b_reg.capture_noise_filter) begin
            // level only flips after four equal samples
            if (cap_hist_reg == {`STC_FILTER_SAMPLES{~cap_level_reg}}) begin
                cap_level_next = ~cap_level_reg;
                cap_hit = (~cap_level_reg == ctrl_b_reg.capture_edge_select);
            end
        end else begin
            cap_level_next = cap_hist_reg[0];
            if (cap_hist_reg[0] != cap_level_reg) begin
                cap_hit = (cap_hist_reg[0] == ctrl_b_reg.capture_edge_select);
            end
        end
    end

    // counter, compare, pwm and capture
    always_comb begin
        pwm_on = (ctrl_a_reg.pwm_resolution != 2'h0);
        unique case (ctrl_a_reg.pwm_resolution)
            2'h1: top = 16'h00ff;
            2'h2: top = 16'h01ff;
            default: top = 16'h03ff;
        endcase
        cnt_next = cnt_reg;
        down_next = down_reg;
        flags_next = flags_reg;
        cmpa_next = cmpa_reg;
        cmpb_next = cmpb_reg;
        cap_next = cap_reg;
        oca_next = oca_reg;
        ocb_next = ocb_reg;
        // a match is registered one cycle late; software loads do not match
        wrote_cnt = req.wr && (req.addr == `STC_ADDR_CNT_LO);
        if (tick) begin
            if (pwm_on) begin
                if (!down_reg) begin
                    if (cnt_reg >= top) begin
                        down_next = 1'b1;
                        cnt_next = cnt_reg - 16'h0001;
                        cmpa_next = cmpa_buf_reg & 16'h03ff;
                        cmpb_next = cmpb_buf_reg & 16'h03ff;
                    end else begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end else if (cnt_reg == 16'h0000) begin
                    down_next = 1'b0;
                    cnt_next = 16'h0001;
                    flags_next[`STC_FLAG_OVF] = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end else begin
                cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg == 16'hffff) begin
                    flags_next[`STC_FLAG_OVF] = 1'b1;
                end
            end
        end
        // match on the value the tick just made, so a cleared count shows it one cycle only
        mata_next = tick && !wrote_cnt && (cnt_next == cmpa_reg);
        matb_next = tick && !wrote_cnt && (cnt_next == cmpb_reg);
        // clear one cycle after match a, beating the next tick
        if (mata_reg && ctrl_b_reg.clear_on_match_a && !pwm_on) begin
            cnt_next = `STC_RESET_WORD;
        end
        if (!pwm_on) begin
            cmpa_next = cmpa_buf_reg;
            cmpb_next = cmpb_buf_reg;
        end
        if (mata_reg) begin
            flags_next[`STC_FLAG_CMPA] = 1'b1;
            if (pwm_on) begin
                if (ctrl_a_reg.compare_a_mode[1]) begin
                    oca_next = down_reg ^ ~ctrl_a_reg.compare_a_mode[0];
                end
            end else begin
                unique case (ctrl_a_reg.compare_a_mode)
                    2'h0: oca_next = oca_reg;
                    2'h1: oca_next = ~oca_reg;
                    2'h2: oca_next = 1'b0;
                    2'h3: oca_next = 1'b1;
                endcase
            end
        end
        if (matb_reg) begin
            flags_next[`STC_FLAG_CMPB] = 1'b1;
            if (pwm_on) begin
                if (ctrl_a_reg.compare_b_mode[1]) begin
                    ocb_next = down_reg ^ ~ctrl_a_reg.compare_b_mode[0];
                end
            end else begin
                unique case (ctrl_a_reg.compare_b_mode)
                    2'h0: ocb_next = ocb_reg;
                    2'h1: ocb_next = ~ocb_reg;
                    2'h2: ocb_next = 1'b0;
                    2'h3: ocb_next = 1'b1;
                endcase
            end
        end
        if (cap_hit) begin
            cap_next = cnt_reg;
        end
        // software write-one clears; hardware set in the same cycle wins
        if (req.wr && req.addr == `STC_ADDR_FLAGS) begin
            flags_next = flags_reg & ~req.wdata[3:0];
            flags_next[`STC_FLAG_OVF] = flags_next[`STC_FLAG_OVF]
                | (tick & ~pwm_on & (cnt_reg == 16'hffff))
                | (tick & pwm_on & down_reg & (cnt_reg == 16'h0000));
            flags_next[`STC_FLAG_CMPA] = flags_next[`STC_FLAG_CMPA] | mata_reg;
            flags_next[`STC_FLAG_CMPB] = flags_next[`STC_FLAG_CMPB] | matb_reg;
        end
        if (cap_hit) begin
            flags_next[`STC_FLAG_CAP] = 1'b1;
        end
        if (wrote_cnt) begin
            cnt_next = {temp_reg, req.wdata};
        end
    end

    // register port
    always_comb begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        mask_next = mask_reg;
        temp_next = temp_reg;
        cmpa_buf_next = cmpa_buf_reg;
        cmpb_buf_next = cmpb_buf_reg;
        rdata_next = `STC_RESET_BYTE;
        if (req.wr) begin
            unique case (req.addr)
                `STC_ADDR_CTRL_A: ctrl_a_next = req.wdata & `STC_CTRL_A_WMASK;
                `STC_ADDR_CTRL_B: ctrl_b_next = req.wdata & `STC_CTRL_B_WMASK;
                `STC_ADDR_MASK: mask_next = req.wdata[3:0];
                `STC_ADDR_CNT_HI, `STC_ADDR_CMPA_HI, `STC_ADDR_CMPB_HI: temp_next = req.wdata;
                `STC_ADDR_CMPA_LO: cmpa_buf_next = {temp_reg, req.wdata};
                `STC_ADDR_CMPB_LO: cmpb_buf_next = {temp_reg, req.wdata};
                default: ;
            endcase
        end
        if (req.rd) begin
            // latest written compare value reads back, even before pwm latches it
            unique case (req.addr)
                `STC_ADDR_CTRL_A: rdata_next = ctrl_a_reg;
                `STC_ADDR_CTRL_B: rdata_next = ctrl_b_reg;
                `STC_ADDR_FLAGS: rdata_next = {4'h0, flags_reg};
                `STC_ADDR_MASK: rdata_next = {4'h0, mask_reg};
                `STC_ADDR_CNT_LO: begin
                    rdata_next = cnt_reg[7:0];
                    temp_next = cnt_reg[15:8];
                end
                `STC_ADDR_CAP_LO: begin
                    rdata_next = cap_reg[7:0];
                    temp_next = cap_reg[15:8];
                end
                `STC_ADDR_CNT_HI, `STC_ADDR_CAP_HI: rdata_next = temp_reg;
                `STC_ADDR_CMPA_LO: rdata_next = cmpa_buf_reg[7:0];
                `STC_ADDR_CMPA_HI: rdata_next = cmpa_buf_reg[15:8];
                `STC_ADDR_CMPB_LO: rdata_next = cmpb_buf_reg[7:0];
                `STC_ADDR_CMPB_HI: rdata_next = cmpb_buf_reg[15:8];
                default: rdata_next = `STC_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl_a_reg <= `STC_RESET_BYTE;
            ctrl_b_reg <= `STC_RESET_BYTE;
            cnt_reg <= `STC_RESET_WORD;
            cmpa_reg <= `STC_RESET_WORD;
            cmpb_reg <= `STC_RESET_WORD;
            cmpa_buf_reg <= `STC_RESET_WORD;
            cmpb_buf_reg <= `STC_RESET_WORD;
            cap_reg <= `STC_RESET_WORD;
            temp_reg <= `STC_RESET_BYTE;
            rdata_reg <= `STC_RESET_BYTE;
            flags_reg <= 4'h0;
            mask_reg <= 4'h0;
            pre_reg <= 10'h000;
            down_reg <= 1'b0;
            oca_reg <= 1'b0;
            ocb_reg <= 1'b0;
            mata_reg <= 1'b0;
            matb_reg <= 1'b0;
            ext_sync_reg <= 2'h0;
            ext_prev_reg <= 1'b0;
            cap_sync_reg <= 2'h0;
            cap_hist_reg <= 4'h0;
            cap_level_reg <= 1'b0;
        end else begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            cnt_reg <= cnt_next;
            cmpa_reg <= cmpa_next;
            cmpb_reg <= cmpb_next;
            cmpa_buf_reg <= cmpa_buf_next;
            cmpb_buf_reg <= cmpb_buf_next;
            cap_reg <= cap_next;
            temp_reg <= temp_next;
            rdata_reg <= rdata_next;
            flags_reg <= flags_next;
            mask_reg <= mask_next;
            pre_reg <= pre_next;
            down_reg <= down_next;
            oca_reg <= oca_next;
            ocb_reg <= ocb_next;
            mata_reg <= mata_next;
            matb_reg <= matb_next;
            ext_sync_reg <= ext_sync_next;
            ext_prev_reg <= ext_prev_next;
            cap_sync_reg <= cap_sync_next;
            cap_hist_reg <= cap_hist_next;
            cap_level_reg <= cap_level_next;
        end
    end

    // pin only driven when its direction bit says output and mode connects it
    assign compare_a_output_pin_o = oca_reg;
    assign compare_b_output_pin_o = ocb_reg;
    assign compare_a_output_pin_oe_o = compare_a_dir_i
        && (pwm_on ? ctrl_a_reg.compare_a_mode[1] : (ctrl_a_reg.compare_a_mode != 2'h0));
    assign compare_b_output_pin_oe_o = compare_b_dir_i
        && (pwm_on ? ctrl_a_reg.compare_b_mode[1] : (ctrl_a_reg.compare_b_mode != 2'h0));
    assign rdata_o = rdata_reg;
    assign timer_flags_o = flags_reg;
    assign irq_o = |(flags_reg & mask_reg);
endmodule : stc_timer

// [sim/stc_timer_monitor.sv]
// port checker for the 16-bit timer/counter
// assumes the ports of stc_timer, attached by the bind below
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_timer_monitor (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // pins and status
    input wire logic compare_a_dir_i,
    input wire logic compare_b_dir_i,
    input wire logic compare_a_output_pin_oe_o,
    input wire logic compare_b_output_pin_oe_o,
    input wire logic [3:0] timer_flags_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence wr_rd_a_s;
        wr_i && addr_i == `STC_ADDR_CTRL_A ##1 rd_i && addr_i == `STC_ADDR_CTRL_A;
    endsequence
    sequence wr_rd_b_s;
        wr_i && addr_i == `STC_ADDR_CTRL_B ##1 rd_i && addr_i == `STC_ADDR_CTRL_B;
    endsequence
    idle_read_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its answer cycle");
    ctrl_a_mask_a: assert property (wr_rd_a_s |=> rdata_o == ($past(wdata_i, 2) & `STC_CTRL_A_WMASK))
        else $error("control a readback wrong");
    ctrl_b_mask_a: assert property (wr_rd_b_s |=> rdata_o == ($past(wdata_i, 2) & `STC_CTRL_B_WMASK))
        else $error("control b readback wrong");
    rsv_a_zero_a: assert property ($past(rd_i) && $past(addr_i) == `STC_ADDR_CTRL_A |-> rdata_o[3:2] == 2'h0)
        else $error("control a reserved bits set");
    rsv_b_zero_a: assert property ($past(rd_i) && $past(addr_i) == `STC_ADDR_CTRL_B |-> rdata_o[5:4] == 2'h0)
        else $error("control b reserved bits set");
    unmapped_read_a: assert property ($past(rd_i) && $past(addr_i) == 6'h3f |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    dir_gate_a_a: assert property (!compare_a_dir_i |-> !compare_a_output_pin_oe_o)
        else $error("pin a driven while input");
    dir_gate_b_a: assert property (!compare_b_dir_i |-> !compare_b_output_pin_oe_o)
        else $error("pin b driven while input");
    irq_has_flag_a: assert property (irq_o |-> timer_flags_o != 4'h0)
        else $error("interrupt without a flag");
endmodule : stc_timer_monitor
bind stc_timer stc_timer_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .compare_a_dir_i(compare_a_dir_i), .compare_b_dir_i(compare_b_dir_i),
    .compare_a_output_pin_oe_o(compare_a_output_pin_oe_o),
    .compare_b_output_pin_oe_o(compare_b_output_pin_oe_o),
    .timer_flags_o(timer_flags_o), .irq_o(irq_o));

// [sim/stc_cpu_model.sv]
// cpu core model driving the timer's byte register port
// assumes every task is entered right after a rising clock edge
`timescale 1ns/1ps
module stc_cpu_model (
    // clock
    input wire logic sys_clk_i,
    // register port
    output logic [5:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 6'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task idle;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
    endtask : idle
    task wr(input logic [5:0] a, input logic [7:0] d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        rd_o <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wr
    task rd(input logic [5:0] a);
        addr_o <= a;
        wdata_o <= ~wdata_o;
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        @(posedge sys_clk_i);
    endtask : rd
    // back to back, so no other latch user can slip in between
    task wr16(input logic [5:0] hi, input logic [5:0] lo, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(lo, v[7:0]);
    endtask : wr16
endmodule : stc_cpu_model

// [sim/test_stc_timer.sv]
// self-checking bench for the 16-bit timer/counter
// assumes stc_cpu_model as bus master and the bound port checker
`timescale 1ns/1ps
`include "stc_map.svh"
module test_stc_timer;
    import stc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] addr;
    logic [7:0] wdata, rdata;
    logic wr, rd, pin_a, pin_b, irq, la, lb;
    logic rd_d = 1'b0;
    logic ext_pin = 1'b0, cap_pin = 1'b0, cmp_res = 1'b0, cmp_sel = 1'b0;
    logic dir_a = 1'b0, dir_b = 1'b0;
    logic [3:0] flags;
    logic [15:0] v, ta, tb;
    logic [15:0] exp_q[$];
    int tol_q[$];
    int failures = 0;
    int checks = 0;
    int divs[6] = '{1, 1, 8, 64, 256, 1024};
    logic [1:0] modes[3] = '{2'h1, 2'h3, 2'h2};
    logic [5:0] regs[4] = '{`STC_ADDR_CNT_LO, `STC_ADDR_CNT_HI, `STC_ADDR_CTRL_A, `STC_ADDR_CTRL_B};
    always #5 sys_clk_i = ~sys_clk_i;
    stc_cpu_model cpu (.sys_clk_i(sys_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    stc_timer DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .external_count_pin_i(ext_pin),
        .capture_trigger_pin_i(cap_pin), .comparator_result_i(cmp_res),
        .comparator_capture_select_i(cmp_sel), .compare_a_dir_i(dir_a), .compare_b_dir_i(dir_b),
        .compare_a_output_pin_o(pin_a), .compare_a_output_pin_oe_o(),
        .compare_b_output_pin_o(pin_b), .compare_b_output_pin_oe_o(),
        .timer_flags_o(flags), .irq_o(irq));
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got, input int t);
        logic ok;
        checks++;
        ok = (got + t >= e) && (got <= e + t);
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input int t);
        exp_q.push_back({8'h00, e});
        tol_q.push_back(t);
        cpu.rd(a);
    endtask : rd_chk
    task run(input int n);
        cpu.idle();
        repeat (n) @(posedge sys_clk_i);
    endtask : run
    task print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // read answers arrive one cycle after the strobe, in issue order
    always @(posedge sys_clk_i) begin
        rd_d <= rd;
        if (rd_d && exp_q.size() > 0) chk("read data", exp_q.pop_front(), {8'h00, rdata}, tol_q.pop_front());
    end
    initial begin
        #800000;
        failures++;
        print_verdict();
    end
    initial begin
        void'($urandom(41));
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        run(2);
        foreach (regs[i]) rd_chk(regs[i], 8'h00, 0);
        rd_chk(6'h3f, 8'h00, 0);
        cpu.wr(`STC_ADDR_CTRL_A, 8'hff);
        rd_chk(`STC_ADDR_CTRL_A, `STC_CTRL_A_WMASK, 0);
        cpu.wr(`STC_ADDR_CTRL_B, 8'hff);
        rd_chk(`STC_ADDR_CTRL_B, `STC_CTRL_B_WMASK, 0);
        cpu.wr(`STC_ADDR_CTRL_A, 8'h00);
        cpu.wr(`STC_ADDR_CTRL_B, 8'h00);
        v = 16'($urandom());
        cpu.wr16(`STC_ADDR_CNT_HI, `STC_ADDR_CNT_LO, v);
        rd_chk(`STC_ADDR_CNT_LO, v[7:0], 0);
        rd_chk(`STC_ADDR_CNT_HI, v[15:8], 0);
        for (int s = 0; s < 6; s++) begin
            cpu.wr16(`STC_ADDR_CNT_HI, `STC_ADDR_CNT_LO, 16'h0000);
            cpu.wr(`STC_ADDR_CTRL_B, 8'(s));
            run(s == 0 ? 100 : 40 * divs[s]);
            cpu.wr(`STC_ADDR_CTRL_B, 8'h00);
            rd_chk(`STC_ADDR_CNT_LO, s == 0 ? 8'h00 : 8'd40, s == 0 ? 0 : 2);
        end
        for (int s = 6; s < 8; s++) begin
            cpu.wr16(`STC_ADDR_CNT_HI, `STC_ADDR_CNT_LO, 16'h0000);
            cpu.wr(`STC_ADDR_CTRL_B, 8'(s));
            run(2);
            repeat (10) begin
                ext_pin <= 1'b1;
                run(3);
                ext_pin <= 1'b0;
                run(3);
            end
            run(6);
            cpu.wr(`STC_ADDR_CTRL_B, 8'h00);
            rd_chk(`STC_ADDR_CNT_LO, 8'd10, 0);
        end
        for (int c = 0; c < 3; c++) begin
            v = 16'($urandom());
            cpu.wr16(`STC_ADDR_CNT_HI, `STC_ADDR_CNT_LO, v);
            cpu.wr(`STC_ADDR_CTRL_B, c == 1 ? 8'h80 : 8'h40);
            cmp_sel <= (c == 2);
            run(4);
            if (c == 2) cmp_res <= 1'b1;
            else cap_pin <= (c == 0);
            run(14);
            rd_chk(`STC_ADDR_CAP_LO, v[7:0], 0);
            rd_chk(`STC_ADDR_CAP_HI, v[15:8], 0);
        end
        cpu.wr(`STC_ADDR_MASK, 8'h0f);
        cpu.wr16(`STC_ADDR_CMPA_HI, `STC_ADDR_CMPA_LO, 16'd5);
        cpu.wr16(`STC_ADDR_CMPB_HI, `STC_ADDR_CMPB_LO, 16'd3);
        cpu.wr16(`STC_ADDR_CNT_HI, `STC_ADDR_CNT_LO, 16'h0000);
        dir_a <= 1'b1;
        dir_b <= 1'b1;
        cpu.wr(`STC_ADDR_CTRL_B, 8'h09);
        foreach (modes[i]) begin
            cpu.wr(`STC_ADDR_CTRL_A, {modes[i], modes[i], 4'h0});
            run(1);
            ta = 16'h0000;
            tb = 16'h0000;
            la = pin_a;
            lb = pin_b;
            repeat (120) begin
                @(posedge sys_clk_i);
                if (pin_a !== la) ta++;
                if (pin_b !== lb) tb++;
                la = pin_a;
                lb = pin_b;
            end
            if (modes[i] == 2'h1) begin
                chk("toggles a", 16'd20, ta, 1);
                chk("toggles b", 16'd20, tb, 1);
            end else begin
                chk("pin a", {15'h0000, modes[i][0]}, {15'h0000, pin_a}, 0);
                chk("pin b", {15'h0000, modes[i][0]}, {15'h0000, pin_b}, 0);
            end
        end
        chk("irq", 16'h0001, {15'h0000, irq}, 0);
        cpu.wr(`STC_ADDR_CTRL_B, 8'h08);
        rd_chk(`STC_ADDR_CNT_LO, 8'd3, 3);
        rd_chk(`STC_ADDR_FLAGS, 8'h0e, 0);
        cpu.wr(`STC_ADDR_FLAGS, 8'h0f);
        cpu.wr16(`STC_ADDR_CNT_HI, `STC_ADDR_CNT_LO, 16'h0000);
        cpu.wr(`STC_ADDR_CTRL_A, 8'h01);
        cpu.wr(`STC_ADDR_CTRL_B, 8'h09);
        run(300);
        cpu.wr(`STC_ADDR_CTRL_B, 8'h08);
        rd_chk(`STC_ADDR_CNT_LO, 8'd210, 3);
        rd_chk(`STC_ADDR_CNT_HI, 8'h00, 0);
        run(4);
        print_verdict();
    end
endmodule : test_stc_timer
